// ### qct_trim_regs.sv
`timescale 1ns/1ns
module qct_trim_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register access from the serial control port
    input wire logic reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    // Mode input
    input wire logic extended_control_mode,
    // Trim codes to the analog side
    output qct_pkg::qct_offset_t offset_trim,
    output logic [14:0] span_magnitude
);
    // Stored register images
    logic [15:0] offset_q, offset_d;
    logic [15:0] span_q, span_d;
    logic [14:0] span_out_q, span_out_d;

    // Next values; reserved bits are not stored, so they read as zero
    always_comb begin
        offset_d = offset_q;
        span_d = span_q;
        if (reg_wr && reg_addr == qct_pkg::QCT_ADDR_OFFSET) begin
            offset_d = {3'h0, reg_wdata[12:0]};
        end
        if (reg_wr && reg_addr == qct_pkg::QCT_ADDR_SPAN) begin
            span_d = {1'h0, reg_wdata[14:0]};
        end
    end

    // Code applied to the span circuit; outside the extended mode the
    // wider range is clamped at the nominal point so it cannot exceed it
    always_comb begin
        if (extended_control_mode) begin
            span_out_d = span_d[14:0];
        end else if (span_d[14:0] > qct_pkg::QCT_SPAN_MID) begin
            span_out_d = qct_pkg::QCT_SPAN_MID;
        end else begin
            span_out_d = span_d[14:0];
        end
    end

    // Registers; images held until rewritten or reset, the applied span code also moving on a mode change
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            offset_q <= qct_pkg::QCT_OFFSET_RST;
            span_q <= qct_pkg::QCT_SPAN_RST;
            span_out_q <= qct_pkg::QCT_SPAN_MID;
        end else begin
            offset_q <= offset_d;
            span_q <= span_d;
            span_out_q <= span_out_d;
        end
    end

    // Reads are pure decode, no side effect
    always_comb begin
        reg_hit = 1'b1;
        unique case (reg_addr)
            qct_pkg::QCT_ADDR_OFFSET: reg_rdata = offset_q;
            qct_pkg::QCT_ADDR_SPAN: reg_rdata = span_q;
            default: begin
                reg_rdata = 16'h0000;
                reg_hit = 1'b0;
            end
        endcase
    end

    // Offset straight binary magnitude with sign; monotonic only in top
    // bits is an analog property, the code passes through unchanged
    assign offset_trim.offset_sign_bit = offset_q[qct_pkg::QCT_SIGN_POS];
    assign offset_trim.offset_magnitude = offset_q[11:0];
    assign span_magnitude = span_out_q;

    AST_OFF_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(reg_wr && reg_addr == qct_pkg::QCT_ADDR_OFFSET) |=> $stable(offset_q))
        else $error("offset trim changed without a write");
    AST_OFF_WR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == qct_pkg::QCT_ADDR_OFFSET |=>
        offset_trim.offset_sign_bit == $past(reg_wdata[12]))
        else $error("sign bit not taken from write");
    AST_OFF_RES: assert property (@(posedge clk_sys) disable iff (sys_rst)
        offset_q[15:13] == 3'h0 && span_q[15] == 1'b0)
        else $error("reserved bits stored nonzero");
    AST_SPAN_LIM: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(extended_control_mode) |-> span_magnitude <= qct_pkg::QCT_SPAN_MID)
        else $error("span above nominal outside extended mode");
    AST_SPAN_ECM: assert property (@(posedge clk_sys) disable iff (sys_rst)
        extended_control_mode |=> span_magnitude == span_q[14:0])
        else $error("extended mode span not passed through");
    AST_SPAN_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(reg_wr && reg_addr == qct_pkg::QCT_ADDR_SPAN) |=> $stable(span_q))
        else $error("span trim changed without a write");
    AST_RD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_addr == qct_pkg::QCT_ADDR_SPAN |-> reg_rdata == span_q && reg_hit)
        else $error("span read mismatch");
    AST_OFF_MAG: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == qct_pkg::QCT_ADDR_OFFSET |=>
        offset_trim.offset_magnitude == $past(reg_wdata[11:0]))
        else $error("offset magnitude not taken from write");

    // Write decodes used by the checks below; they mirror the strobe
    // qualification of the next-value logic so the checks read plainly
    logic wr_offset;
    logic wr_span;
    assign wr_offset = reg_wr && (reg_addr == qct_pkg::QCT_ADDR_OFFSET);
    assign wr_span = reg_wr && (reg_addr == qct_pkg::QCT_ADDR_SPAN);

    // First edge after reset: offset image and its output are at zero
    // offset, whatever was stored before the reset
    AST_RST_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |->
        offset_q == qct_pkg::QCT_OFFSET_RST && offset_trim.offset_magnitude == 12'h000)
        else $error("offset trim not at default after reset");

    // First edge after reset: span image at its default and the applied
    // code at the nominal point, in either mode
    AST_RST_SPAN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |->
        span_q == qct_pkg::QCT_SPAN_RST && span_magnitude == qct_pkg::QCT_SPAN_MID)
        else $error("span trim not at default after reset");

    // A span write stores the whole magnitude field and clears the
    // reserved top bit, so reads never echo a stray one there
    AST_SPAN_WR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_span |=>
        span_q == {1'b0, $past(reg_wdata[14:0])})
        else $error("span magnitude not taken from write");

    // Offset reads return the stored image and flag a hit; the read
    // path is a pure mux so it cannot disturb the stored value
    AST_OFF_RD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_addr == qct_pkg::QCT_ADDR_OFFSET |->
        reg_rdata == offset_q && reg_hit)
        else $error("offset read mismatch");

    // Any other index reads as zero with no hit, so a host can tell a
    // missed address from a stored zero
    AST_MISS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_addr != qct_pkg::QCT_ADDR_OFFSET && reg_addr != qct_pkg::QCT_ADDR_SPAN |->
        reg_rdata == 16'h0000 && !reg_hit)
        else $error("unmapped read not empty");

    // Outside the extended mode a wide stored code is applied only as
    // the nominal point; the register itself still keeps the wide code
    AST_SPAN_CLAMP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !extended_control_mode && !wr_span && span_q[14:0] > qct_pkg::QCT_SPAN_MID |=>
        span_magnitude == qct_pkg::QCT_SPAN_MID)
        else $error("wide span applied outside extended mode");

    // Codes at or below the midpoint pass unchanged in both modes, so
    // the low half of the span range is always reachable
    AST_SPAN_PASS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_span && span_q[14:0] <= qct_pkg::QCT_SPAN_MID |=>
        span_magnitude == $past(span_q[14:0]))
        else $error("low span code not passed through");

    // The midpoint code gives the nominal span whichever mode is set;
    // a mode change alone must not move the nominal setting
    AST_SPAN_MIDPT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_span && span_q[14:0] == qct_pkg::QCT_SPAN_MID |=>
        span_magnitude == qct_pkg::QCT_SPAN_MID)
        else $error("midpoint span differs between modes");

    // The sign seen by the analog side moves only on an offset write;
    // a glitch here would flip the offset polarity for a cycle
    AST_SIGN_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_offset |=>
        $stable(offset_trim.offset_sign_bit))
        else $error("offset sign moved without a write");

    // The offset magnitude seen by the analog side moves only on an
    // offset write, never on a span write or a read
    AST_MAG_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_offset |=>
        $stable(offset_trim.offset_magnitude))
        else $error("offset magnitude moved without a write");

    // With no span write and a steady mode the applied span code stays
    // put; the analog side would see a step otherwise
    AST_SPAN_STEADY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_span && $stable(extended_control_mode) |=>
        $stable(span_magnitude))
        else $error("span code moved without a cause");

    // The half-range offset code reaches the output intact; the top bit
    // alone must not be lost or shifted on the way
    AST_HALF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_offset && reg_wdata[11:0] == 12'h800 |=>
        offset_trim.offset_magnitude == 12'h800)
        else $error("half-range offset code not applied");

    // In the extended mode a written span code, wide ones included,
    // reaches the analog side one cycle after the write
    AST_SPAN_EXT_WR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        extended_control_mode && wr_span |=>
        span_magnitude == $past(reg_wdata[14:0]))
        else $error("extended mode span write not applied");

    // The nine top span bits, the only ones trusted to step in order,
    // are stored exactly as written with no rounding or reordering
    AST_SPAN_TOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_span |=>
        span_q[14:6] == $past(reg_wdata[14:6]))
        else $error("span top bits not stored as written");
endmodule : qct_trim_regs

// ### qct_pkg.sv
package qct_pkg;
    // Register indices on the serial control port
    localparam logic [3:0] QCT_ADDR_OFFSET = 4'ha;
    localparam logic [3:0] QCT_ADDR_SPAN = 4'hb;
    // Reset values
    localparam logic [15:0] QCT_OFFSET_RST = 16'h0000;
    localparam logic [15:0] QCT_SPAN_RST = 16'h4000;
    // Field positions and widths
    localparam int QCT_SIGN_POS = 12;
    localparam int QCT_OMAG_W = 12;
    localparam int QCT_SMAG_W = 15;
    localparam int QCT_MONO_BITS = 9;
    // Span code that gives the nominal span outside the extended mode
    localparam logic [14:0] QCT_SPAN_MID = 15'h4000;
    // Offset trim fields as seen by the analog side
    typedef struct packed {
        logic offset_sign_bit;
        logic [11:0] offset_magnitude;
    } qct_offset_t;
endpackage : qct_pkg

// ### tb_qct_trim_regs.sv
`timescale 1ns/1ns
module tb_qct_trim_regs;
    // Stimulus, driven on the falling edge; read addresses may follow it by 1 ns
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic extended_control_mode = 1'b0;
    // Observed outputs
    logic [15:0] reg_rdata;
    logic reg_hit;
    qct_pkg::qct_offset_t offset_trim;
    logic [14:0] span_magnitude;
    int error_cnt = 0;
    int check_count = 0;
    qct_trim_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .extended_control_mode(extended_control_mode), .offset_trim(offset_trim),
        .span_magnitude(span_magnitude));
    // 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // Four-state compare so an unknown never matches
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : cmp
    // One-cycle write strobe straddling a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    // Reads are combinational; let them settle first
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr = a;
        #1 cmp(reg_rdata, exp);
    endtask : rd
    // Single exit point of the run
    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(4'ha, 16'h0000);
        rd(4'hb, 16'h4000);
        cmp({1'b0, span_magnitude}, 16'h4000);
        $display("Reset test done");
        // Reserved bits dropped, full magnitude with negative sign
        wr(4'ha, 16'hffff);
        rd(4'ha, 16'h1fff);
        cmp({3'h0, offset_trim}, 16'h1fff);
        wr(4'ha, 16'h1800);
        cmp({3'h0, offset_trim}, 16'h1800);
        wr(4'ha, 16'h0800);
        cmp({3'h0, offset_trim}, 16'h0800);
        // Unmapped write leaves the offset trim alone
        wr(4'h5, 16'hffff);
        rd(4'h5, 16'h0000);
        cmp({15'h0, reg_hit}, 16'h0000);
        rd(4'ha, 16'h0800);
        $display("Offset test done");
        // Wide span is held at nominal until the extended mode is on
        wr(4'hb, 16'hffff);
        rd(4'hb, 16'h7fff);
        cmp({1'b0, span_magnitude}, 16'h4000);
        @(negedge clk_sys);
        extended_control_mode = 1'b1;
        @(negedge clk_sys);
        cmp({1'b0, span_magnitude}, 16'h7fff);
        wr(4'hb, 16'h4000);
        cmp({1'b0, span_magnitude}, 16'h4000);
        wr(4'hb, 16'h0000);
        cmp({1'b0, span_magnitude}, 16'h0000);
        $display("Span test done");
        // Mid-run reset returns both trims to their defaults
        wr(4'ha, 16'h1abc);
        rd(4'ha, 16'h1abc);
        @(negedge clk_sys);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(4'ha, 16'h0000);
        rd(4'hb, 16'h4000);
        cmp({1'b0, span_magnitude}, 16'h4000);
        cmp({3'h0, offset_trim}, 16'h0000);
        $display("Mid-run reset test done");
        conclude();
    end
endmodule : tb_qct_trim_regs
